// ---- core/dsc_regs.vh ----
// register offsets, field positions and reset values of the modulator and sweep config bank
// assumes a 5-bit register address and 30-bit data, one register per address
`ifndef DSC_REGS_VH
`define DSC_REGS_VH

`define DSC_AW 5
`define DSC_DW 30

`define DSC_OFS_SEED_LOW 5'h0b
`define DSC_OFS_DN_STEP_HIGH 5'h0c
`define DSC_OFS_DN_STEP_LOW 5'h0d
`define DSC_OFS_MOD_CFG 5'h0e
`define DSC_OFS_STATUS 5'h1f

`define DSC_RST_SEED_LOW 18'h10081
`define DSC_RST_DN_STEP_HIGH 30'h0000000
`define DSC_RST_DN_STEP_LOW 18'h00000
`define DSC_RST_MOD_CFG 30'h04478173

`define DSC_F_MOD_TYPE 1:0
`define DSC_B_AUTO_RPT 2
`define DSC_B_AUTO_RPT_ON 3
`define DSC_F_INT_DELAY 6:4
`define DSC_B_START_DLY 7
`define DSC_B_AUTOSEED 8
`define DSC_B_KEEP_STATE 10
`define DSC_B_SWEEP_EN 11
`define DSC_B_SW_START 12
`define DSC_B_TRIG_SWEEP 13
`define DSC_B_BYPASS 14
`define DSC_F_CSG_STEP 18:15
`define DSC_B_EXT_SEQ 19
`define DSC_B_SEQ_FALL 20
`define DSC_B_TRIG_LOCK 21
`define DSC_B_SYMMETRIC 22
`define DSC_B_LOCK_STROBE 23
`define DSC_B_SINGLE_STEP 24
`define DSC_B_ONE_WAY 25
`define DSC_B_START_UP 26
`define DSC_B_EXT_CLK 27
`define DSC_B_CSG_X16 29

`define DSC_MOD_B 2'b10
`define DSC_MOD_A 2'b11
`define DSC_DLY_NONE 3'b000
`define DSC_DLY_SIX 3'b110
`define DSC_DLY_AUTO 3'b111
`define DSC_CSG_X16_SHIFT 4

`define DSC_ST_IDLE 2'b00
`define DSC_ST_WAIT 2'b01
`define DSC_ST_LEG 2'b10

`endif

// ---- core/dsc_sweep_config.v ----
// modulator and frequency-sweep configuration bank with its sweep sequencer
// assumes one 20 MHz clock; set-point and dwell values arrive from neighbouring registers
// Summary of operation
// - seed low register holds 18 low bits of first accumulator seed.
// - down step count is 30-bit high plus 18-bit low, one 48-bit value.
// - two-bit modulator type; 10 three-stage cascade, 11 mode A default.
// - sweep repeats at its end only if both auto-repeat bits set.
// - three-bit integer path delay; 000 none, 110 six cycles, 111 auto.
// - start-delay bit holds off sweep start by integer set-point count.
// - autoseed, default on, reloads seed whenever fractional set-point changes.
// - maintain-state keeps modulator state while integer part is unchanged.
// - sweep enable bit switches modulator from fixed frequency to sweeping.
// - writing software start bit as one starts a sweep.
// - external-trigger bit lets trigger pin start and step the sweep.
// - bypass bit forces integer mode while modulator stays enabled.
// - four-bit slip-guard step, default 1111, times sixteen when x16 set.
// - external sequence bit selects sequence imported on GPIO port.
// - falling-edge bit samples imported sequence on GPIO clock falling edge when external clock set.
// - trigger-lock ignores ratio writes; locking starts on trigger rising.
// - symmetric default; otherwise down step count from separate down registers.
// - integer lock strobe re-locks whenever integer set-point register updated.
// - single-step mode advances one step per software or pin strobe.
// - one-way mode sweeps one direction then jumps back to base.
// - start direction one up, zero down; latched only while sweep disabled.
// - external clock bit clocks modulator from GPIO clock pin.
// - in sweep mode integer set-point is the hardware trigger delay count.
// - asymmetric down dwell comes from fractional set-point high and low parts.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_regs.vh"

module dsc_sweep_config (
    input wire SYS_CLK,
    input wire SRST,
    input wire [`DSC_AW-1:0] ADDR,
    input wire [`DSC_DW-1:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [`DSC_DW-1:0] RDATA,
    input wire [19:0] INT_SETPOINT,
    input wire INT_WR,
    input wire [47:0] FRAC_SETPOINT,
    input wire FRAC_WR,
    input wire [47:0] UP_STEPS,
    input wire [47:0] UP_DWELL,
    input wire EXT_TRIG,
    input wire EXT_MOD_CLK,
    input wire [3:0] EXT_SEQ,
    output reg [17:0] SEED_LOW,
    output reg SEED_LOAD,
    output reg [1:0] MOD_TYPE,
    output reg [2:0] INT_PATH_DELAY,
    output reg BYPASS_INT,
    output reg MOD_ENABLE,
    output reg [7:0] CSG_STEP,
    output reg SEQ_EXT_SEL,
    output reg [3:0] SEQ_SAMPLE,
    output reg MOD_TICK,
    output reg [19:0] INT_RATIO,
    output reg [47:0] FRAC_RATIO,
    output reg LOCK_START,
    output reg SWEEP_MODE,
    output reg SWEEP_ACTIVE,
    output reg SWEEP_UP,
    output reg STEP_PULSE,
    output reg BASE_RETURN,
    output reg SWEEP_DONE
);

    reg [17:0] seed_low;
    reg [29:0] dn_step_high;
    reg [17:0] dn_step_low;
    reg [29:0] cfg;

    // pin inputs: two flops each, third stage only for edge detection
    reg trig_s1, trig_s2, trig_s3;
    reg clk_s1, clk_s2, clk_s3;
    reg [3:0] seq_s1, seq_s2;

    reg [1:0] state;
    reg leg;
    reg start_up;
    reg [47:0] steps_left;
    reg [47:0] dwell_cnt;
    reg [19:0] delay_cnt;
    reg int_changed;

    wire wr_cfg = WR && (ADDR == `DSC_OFS_MOD_CFG);
    wire sw_start = wr_cfg && WDATA[`DSC_B_SW_START];
    wire trig_rise = trig_s2 && !trig_s3;
    wire mclk_rise = clk_s2 && !clk_s3;
    wire mclk_fall = !clk_s2 && clk_s3;
    wire sweep_en = cfg[`DSC_B_SWEEP_EN];
    wire trig_ok = cfg[`DSC_B_TRIG_SWEEP] && trig_rise;
    wire strobe = sw_start || trig_ok;
    wire auto_rpt = cfg[`DSC_B_AUTO_RPT] && cfg[`DSC_B_AUTO_RPT_ON];
    wire sym = cfg[`DSC_B_SYMMETRIC];
    wire [47:0] dn_steps = {dn_step_high, dn_step_low};
    wire [47:0] steps_first = start_up ? UP_STEPS : (sym ? UP_STEPS : dn_steps);
    wire [47:0] steps_second = start_up ? (sym ? UP_STEPS : dn_steps) : UP_STEPS;
    wire [47:0] dwell_cur = (SWEEP_UP || sym) ? UP_DWELL : FRAC_SETPOINT;
    wire step_ev = cfg[`DSC_B_SINGLE_STEP] ? strobe : (dwell_cnt >= dwell_cur);
    wire lock_mode = cfg[`DSC_B_TRIG_LOCK];
    wire int_take = INT_WR && !lock_mode;
    wire frac_take = FRAC_WR && !lock_mode;
    wire mod_tick = cfg[`DSC_B_EXT_CLK] ? mclk_rise : 1'b1;
    wire seq_edge = cfg[`DSC_B_EXT_CLK] ?
        (cfg[`DSC_B_SEQ_FALL] ? mclk_fall : mclk_rise) : 1'b1;

    // register writes; reserved bits 9 and 28 are simply stored
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            seed_low <= `DSC_RST_SEED_LOW;
            dn_step_high <= `DSC_RST_DN_STEP_HIGH;
            dn_step_low <= `DSC_RST_DN_STEP_LOW;
            cfg <= `DSC_RST_MOD_CFG;
        end else if (WR) begin
            case (ADDR)
                `DSC_OFS_SEED_LOW: seed_low <= WDATA[17:0];
                `DSC_OFS_DN_STEP_HIGH: dn_step_high <= WDATA;
                `DSC_OFS_DN_STEP_LOW: dn_step_low <= WDATA[17:0];
                `DSC_OFS_MOD_CFG: cfg <= WDATA;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero for unmapped addresses
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            RDATA <= {`DSC_DW{1'b0}};
        end else if (RD) begin
            case (ADDR)
                `DSC_OFS_SEED_LOW: RDATA <= {12'h000, seed_low};
                `DSC_OFS_DN_STEP_HIGH: RDATA <= dn_step_high;
                `DSC_OFS_DN_STEP_LOW: RDATA <= {12'h000, dn_step_low};
                `DSC_OFS_MOD_CFG: RDATA <= cfg;
                `DSC_OFS_STATUS: RDATA <= {25'h0000000, start_up, leg, SWEEP_UP, state};
                default: RDATA <= {`DSC_DW{1'b0}};
            endcase
        end else begin
            RDATA <= {`DSC_DW{1'b0}};
        end
    end

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            seq_s1 <= 4'h0;
            seq_s2 <= 4'h0;
        end else begin
            trig_s1 <= EXT_TRIG;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            clk_s1 <= EXT_MOD_CLK;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            seq_s1 <= EXT_SEQ;
            seq_s2 <= seq_s1;
        end
    end

    // configuration outputs, plus the sampled sequence and the modulator tick
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            SEED_LOW <= `DSC_RST_SEED_LOW;
            MOD_TYPE <= `DSC_MOD_A;
            INT_PATH_DELAY <= `DSC_DLY_AUTO;
            BYPASS_INT <= 1'b0;
            MOD_ENABLE <= 1'b0;
            CSG_STEP <= 8'h0f;
            SEQ_EXT_SEL <= 1'b0;
            SEQ_SAMPLE <= 4'h0;
            MOD_TICK <= 1'b0;
            SWEEP_MODE <= 1'b0;
        end else begin
            SEED_LOW <= seed_low;
            MOD_TYPE <= cfg[`DSC_F_MOD_TYPE];
            INT_PATH_DELAY <= cfg[`DSC_F_INT_DELAY];
            BYPASS_INT <= cfg[`DSC_B_BYPASS];
            MOD_ENABLE <= 1'b1;
            if (cfg[`DSC_B_CSG_X16])
                CSG_STEP <= {cfg[`DSC_F_CSG_STEP], 4'h0};
            else
                CSG_STEP <= {4'h0, cfg[`DSC_F_CSG_STEP]};
            SEQ_EXT_SEL <= cfg[`DSC_B_EXT_SEQ];
            if (cfg[`DSC_B_EXT_SEQ] && seq_edge)
                SEQ_SAMPLE <= seq_s2;
            MOD_TICK <= mod_tick;
            SWEEP_MODE <= sweep_en;
        end
    end

    // set-point capture, reseed and lock requests
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            INT_RATIO <= 20'h00000;
            FRAC_RATIO <= 48'h000000000000;
            SEED_LOAD <= 1'b0;
            LOCK_START <= 1'b0;
            int_changed <= 1'b0;
        end else begin
            SEED_LOAD <= 1'b0;
            LOCK_START <= 1'b0;
            if (lock_mode && trig_rise) begin
                INT_RATIO <= INT_SETPOINT;
                FRAC_RATIO <= FRAC_SETPOINT;
                LOCK_START <= 1'b1;
            end
            // clear before set so a same-cycle integer change is not lost
            if (frac_take)
                int_changed <= 1'b0;
            if (int_take) begin
                INT_RATIO <= INT_SETPOINT;
                if (INT_SETPOINT != INT_RATIO)
                    int_changed <= 1'b1;
                if (cfg[`DSC_B_LOCK_STROBE])
                    LOCK_START <= 1'b1;
            end
            if (frac_take) begin
                FRAC_RATIO <= FRAC_SETPOINT;
                // keeping state only pays off while the integer part stays put
                if (cfg[`DSC_B_AUTOSEED] && !(cfg[`DSC_B_KEEP_STATE] && !int_changed))
                    SEED_LOAD <= 1'b1;
            end
        end
    end

    // sweep sequencer
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            state <= `DSC_ST_IDLE;
            leg <= 1'b0;
            start_up <= 1'b1;
            steps_left <= 48'h000000000000;
            dwell_cnt <= 48'h000000000000;
            delay_cnt <= 20'h00000;
            SWEEP_ACTIVE <= 1'b0;
            SWEEP_UP <= 1'b1;
            STEP_PULSE <= 1'b0;
            BASE_RETURN <= 1'b0;
            SWEEP_DONE <= 1'b0;
        end else begin
            STEP_PULSE <= 1'b0;
            BASE_RETURN <= 1'b0;
            SWEEP_DONE <= 1'b0;
            if (!sweep_en)
                start_up <= cfg[`DSC_B_START_UP];
            if (!sweep_en) begin
                state <= `DSC_ST_IDLE;
                SWEEP_ACTIVE <= 1'b0;
                SWEEP_UP <= start_up;
            end else begin
                case (state)
                    `DSC_ST_IDLE: begin
                        if (strobe) begin
                            SWEEP_ACTIVE <= 1'b1;
                            if (cfg[`DSC_B_START_DLY] && INT_SETPOINT != 20'h00000) begin
                                delay_cnt <= INT_SETPOINT;
                                state <= `DSC_ST_WAIT;
                            end else begin
                                state <= `DSC_ST_LEG;
                                leg <= 1'b0;
                                SWEEP_UP <= start_up;
                                steps_left <= steps_first;
                                dwell_cnt <= 48'h000000000000;
                            end
                        end
                    end
                    `DSC_ST_WAIT: begin
                        delay_cnt <= delay_cnt - 20'h00001;
                        if (delay_cnt == 20'h00001) begin
                            state <= `DSC_ST_LEG;
                            leg <= 1'b0;
                            SWEEP_UP <= start_up;
                            steps_left <= steps_first;
                            dwell_cnt <= 48'h000000000000;
                        end
                    end
                    `DSC_ST_LEG: begin
                        dwell_cnt <= dwell_cnt + 48'h000000000001;
                        if (step_ev) begin
                            STEP_PULSE <= 1'b1;
                            dwell_cnt <= 48'h000000000000;
                            steps_left <= steps_left - 48'h000000000001;
                            // a zero count behaves as a single step
                            if (steps_left <= 48'h000000000001) begin
                                if (!leg && !cfg[`DSC_B_ONE_WAY]) begin
                                    leg <= 1'b1;
                                    SWEEP_UP <= !SWEEP_UP;
                                    steps_left <= steps_second;
                                end else begin
                                    if (!leg)
                                        BASE_RETURN <= 1'b1;
                                    SWEEP_DONE <= 1'b1;
                                    leg <= 1'b0;
                                    SWEEP_UP <= start_up;
                                    if (auto_rpt) begin
                                        steps_left <= steps_first;
                                    end else begin
                                        state <= `DSC_ST_IDLE;
                                        SWEEP_ACTIVE <= 1'b0;
                                    end
                                end
                            end
                        end
                    end
                    default: begin
                        state <= `DSC_ST_IDLE;
                        SWEEP_ACTIVE <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // dsc_sweep_config
`default_nettype wire

// ---- sim/dsc_sweep_config_checker.sv ----
// assertions on the modulator and sweep config bank, kept against a shadow of the config register
// assumes one clock, synchronous active-high reset, and binding to dsc_sweep_config
`timescale 1ns/1ns
`default_nettype none
`include "dsc_regs.vh"
module dsc_sweep_config_checker (
    input wire SYS_CLK,
    input wire SRST,
    input wire [4:0] ADDR,
    input wire [29:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [29:0] RDATA,
    input wire [19:0] INT_SETPOINT,
    input wire INT_WR,
    input wire FRAC_WR,
    input wire SEED_LOAD,
    input wire [1:0] MOD_TYPE,
    input wire [2:0] INT_PATH_DELAY,
    input wire BYPASS_INT,
    input wire [7:0] CSG_STEP,
    input wire SEQ_EXT_SEL,
    input wire [19:0] INT_RATIO,
    input wire LOCK_START,
    input wire SWEEP_MODE,
    input wire SWEEP_ACTIVE,
    input wire STEP_PULSE,
    input wire SWEEP_DONE
);
    reg [29:0] cfg;
    wire cfg_wr = WR && ADDR == `DSC_OFS_MOD_CFG;
    // shadow only; the config outputs lag it by one register stage
    always @(posedge SYS_CLK) begin
        if (SRST) cfg <= 30'h4478173;
        else if (cfg_wr) cfg <= WDATA;
    end
    default clocking dcb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    mod_copy_a: assert property (
        {MOD_TYPE, INT_PATH_DELAY} == {$past(cfg[1:0]), $past(cfg[6:4])})
        else $error("type or delay copy wrong");
    flag_copy_a: assert property (
        {BYPASS_INT, SEQ_EXT_SEL, SWEEP_MODE} == {$past(cfg[14]), $past(cfg[19]), $past(cfg[11])})
        else $error("mode flag copy wrong");
    guard_step_a: assert property (CSG_STEP == ($past(cfg[29]) ?
        {$past(cfg[18:15]), 4'h0} : {4'h0, $past(cfg[18:15])})) else $error("guard step wrong");
    int_lock_a: assert property (INT_WR && !cfg[21] |=>
        INT_RATIO == $past(INT_SETPOINT) && LOCK_START == $past(cfg[23]))
        else $error("integer write effect wrong");
    reseed_on_a: assert property (FRAC_WR && !cfg[21] && !cfg[10] |=>
        SEED_LOAD == $past(cfg[8])) else $error("reseed pulse wrong");
    soft_start_a: assert property (cfg_wr && WDATA[12] && WDATA[11] && cfg[11]
        && !SWEEP_ACTIVE |=> SWEEP_ACTIVE) else $error("software start missed");
    step_hold_a: assert property (SWEEP_ACTIVE && cfg[24] && !cfg[13]
        && !(cfg_wr && WDATA[12]) |=> !STEP_PULSE) else $error("step without strobe");
    no_repeat_a: assert property (
        SWEEP_DONE && !(cfg[2] && cfg[3]) |-> !SWEEP_ACTIVE) else $error("sweep kept running");
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 30'h0) else $error("read data not idle");
    cover property (SWEEP_DONE);
    cover property (LOCK_START);
    cover property (SEED_LOAD);
endmodule // dsc_sweep_config_checker
bind dsc_sweep_config dsc_sweep_config_checker u_chk (.*);
`default_nettype wire

// ---- sim/dsc_far_model.sv ----
// trigger pin and GPIO modulator clock and sequence as driven from outside the device
// assumes the same clock as the bench; pins change on the device's rising clock edge
`timescale 1ns/1ns
`default_nettype none
module dsc_far_model (
    input wire logic SYS_CLK,
    input wire logic fire,
    output logic ext_trig,
    output logic ext_mod_clk,
    output logic [3:0] ext_seq
);
    logic [2:0] hold = 3'h0;
    logic [1:0] div = 2'h0;
    // held high several cycles so the two-flop synchroniser cannot miss it
    assign ext_trig = hold != 3'h0;
    assign ext_mod_clk = div[1];
    always @(posedge SYS_CLK) begin
        hold <= fire ? 3'h4 : hold - (hold != 3'h0);
        div <= div + 2'h1;
        if (div == 2'h3) ext_seq <= ext_seq + 4'h1;
    end
    initial ext_seq = 4'h0;
endmodule // dsc_far_model
`default_nettype wire

// ---- sim/dsc_sweep_config_tb.sv ----
// self-checking bench for the modulator and sweep configuration bank
// assumes core/ on the include path and the checker bound to the design
`timescale 1ns/1ns
`default_nettype none
`include "dsc_regs.vh"
module dsc_sweep_config_tb;
    logic SYS_CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, INT_WR = 1'b0;
    logic FRAC_WR = 1'b0, fire = 1'b0;
    logic [3:0] seq_h1 = 4'h0, seq_h2 = 4'h0, seq_h3 = 4'h0;
    logic [4:0] ADDR = 5'h00;
    logic [29:0] WDATA = 30'h0;
    logic [19:0] INT_SETPOINT = 20'h0;
    logic [47:0] FRAC_SETPOINT = 48'h0, UP_STEPS = 48'h1, UP_DWELL = 48'h2;
    wire EXT_TRIG, EXT_MOD_CLK, SEED_LOAD, BYPASS_INT, MOD_ENABLE, SEQ_EXT_SEL, MOD_TICK;
    wire LOCK_START, SWEEP_MODE, SWEEP_ACTIVE, SWEEP_UP, STEP_PULSE, BASE_RETURN, SWEEP_DONE;
    wire [3:0] EXT_SEQ, SEQ_SAMPLE;
    wire [29:0] RDATA;
    wire [17:0] SEED_LOW;
    wire [1:0] MOD_TYPE;
    wire [2:0] INT_PATH_DELAY;
    wire [7:0] CSG_STEP;
    wire [19:0] INT_RATIO;
    wire [47:0] FRAC_RATIO;
    int errors = 0, checked = 0, cycles = 0, n, k, m;
    logic [29:0] tv [3];
    logic [14:0] te [3];
    int tk [3];
    dsc_sweep_config dut (.*);
    dsc_far_model far (.SYS_CLK(SYS_CLK), .fire(fire), .ext_trig(EXT_TRIG),
        .ext_mod_clk(EXT_MOD_CLK), .ext_seq(EXT_SEQ));
    initial forever #25 SYS_CLK = ~SYS_CLK;
    task chk(input [47:0] seen, input [47:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input [4:0] a, input [29:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task rd(input [4:0] a, input [29:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask
    task cw(input [29:0] d);
        wr(`DSC_OFS_MOD_CFG, d);
        @(posedge SYS_CLK) #1;
    endtask
    task sp(input i, input [19:0] v, input [1:0] e);
        @(posedge SYS_CLK);
        INT_SETPOINT <= v;
        FRAC_SETPOINT <= {28'h0, v};
        INT_WR <= i;
        FRAC_WR <= !i;
        @(posedge SYS_CLK);
        INT_WR <= 1'b0;
        FRAC_WR <= 1'b0;
        #1 chk({LOCK_START, SEED_LOAD}, e);
    endtask
    task pin;
        @(posedge SYS_CLK);
        fire <= 1'b1;
        @(posedge SYS_CLK);
        fire <= 1'b0;
    endtask
    // generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        seq_h1 <= EXT_SEQ;
        seq_h2 <= seq_h1;
        seq_h3 <= seq_h2;
        if (cycles == 4000) begin
            errors = errors + 1;
            results();
        end
    end
    initial begin
        tv = '{30'h344ac302, 30'hc580163, 30'h4478173};
        te = '{{5'b10000, 2'b11, 8'h50}, {5'b11110, 2'b01, 8'h00}, {5'b11111, 2'b00, 8'h0f}};
        tk = '{16, 4, 16};
        repeat (4) @(posedge SYS_CLK);
        SRST <= 1'b0;
        rd(`DSC_OFS_SEED_LOW, 30'h10081);
        rd(`DSC_OFS_DN_STEP_LOW, 30'h0);
        rd(`DSC_OFS_MOD_CFG, 30'h4478173);
        wr(`DSC_OFS_SEED_LOW, 30'h3fffffff);
        wr(`DSC_OFS_DN_STEP_HIGH, 30'h2aaaaaaa);
        wr(`DSC_OFS_DN_STEP_LOW, 30'h3fffffff);
        wr(5'h01, 30'h3fffffff);
        rd(`DSC_OFS_SEED_LOW, 30'h3ffff);
        rd(`DSC_OFS_DN_STEP_HIGH, 30'h2aaaaaaa);
        rd(`DSC_OFS_DN_STEP_LOW, 30'h3ffff);
        rd(5'h01, 30'h0);
        chk(SEED_LOW, 18'h3ffff);
        chk(MOD_ENABLE, 1'b1);
        for (k = 0; k < 3; k++) begin
            cw(tv[k]);
            chk({MOD_TYPE, INT_PATH_DELAY, BYPASS_INT, SEQ_EXT_SEL, CSG_STEP}, te[k]);
            rd(`DSC_OFS_MOD_CFG, tv[k]);
            n = 0;
            repeat (16) begin
                @(posedge SYS_CLK) #1 n += MOD_TICK;
                if (k < 2) chk(SEQ_SAMPLE, seq_h3);
            end
            chk(n, tk[k]);
        end
        sp(1'b1, 20'h00123, 2'b00);
        chk(INT_RATIO, 20'h00123);
        sp(1'b0, 20'h00456, 2'b01);
        chk(FRAC_RATIO, 48'h456);
        cw(30'h4c78073);
        sp(1'b1, 20'h00124, 2'b10);
        sp(1'b0, 20'h00457, 2'b00);
        cw(30'h4478573);
        sp(1'b0, 20'h00458, 2'b00);
        sp(1'b1, 20'h00125, 2'b00);
        sp(1'b0, 20'h00459, 2'b01);
        cw(30'h4678173);
        sp(1'b1, 20'h00777, 2'b00);
        chk(INT_RATIO, 20'h00125);
        pin();
        for (n = 0; n < 12 && LOCK_START !== 1'b1; n++) @(posedge SYS_CLK) #1;
        chk({LOCK_START, INT_RATIO}, {1'b1, 20'h00777});
        cw(30'h7478973);
        wr(`DSC_OFS_MOD_CFG, 30'h7479973);
        #1 chk({SWEEP_ACTIVE, SWEEP_UP}, 2'b11);
        wr(`DSC_OFS_MOD_CFG, 30'h7479973);
        #1 chk({STEP_PULSE, BASE_RETURN, SWEEP_DONE, SWEEP_ACTIVE}, 4'b1110);
        cw(30'h4478173);
        sp(1'b1, 20'h00005, 2'b00);
        wr(`DSC_OFS_DN_STEP_HIGH, 30'h0);
        wr(`DSC_OFS_DN_STEP_LOW, 30'h1);
        for (k = 0; k < 3; k++) begin
            cw(k == 2 ? 30'h447a9ff : (k == 1 ? 30'h407a9f3 : 30'h447a9f3));
            pin();
            n = 0;
            for (m = 0; m < 80 && n < 2; m++) begin
                @(posedge SYS_CLK) #1;
                if (m < 9) chk(STEP_PULSE, 1'b0);
                n += STEP_PULSE;
            end
            chk({n, SWEEP_DONE}, {32'd2, 1'b1});
            chk(m, (k == 1) ? 17 : 14);
            repeat (2) @(posedge SYS_CLK);
            #1 chk(SWEEP_ACTIVE, k == 2);
        end
        cw(30'h4478173);
        repeat (2) @(posedge SYS_CLK);
        #1 chk(SWEEP_ACTIVE, 1'b0);
        results();
    end
endmodule // dsc_sweep_config_tb
`default_nettype wire
